// *** logic/mag_cfg_pkg.sv ***
// Register map, field layout and decode constants for the magnetic channel config block
package mag_cfg_pkg;
    localparam logic [7:0] ADDR_CHAN_SET   = 8'h90;
    localparam logic [7:0] ADDR_TUNE_SET   = 8'h91;
    localparam logic [7:0] ADDR_COMP_LOW   = 8'h92;
    localparam logic [7:0] ADDR_MULT_COMP  = 8'h93;
    localparam logic [7:0] ADDR_SW_SET     = 8'ha0;
    localparam logic [7:0] ADDR_SW_NEAR    = 8'ha1;
    localparam logic [7:0] ADDR_SW_CONTACT = 8'ha2;

    localparam logic [7:0] RST_CHAN_SET    = 8'h03;
    localparam logic [7:0] RST_TUNE_SET    = 8'h50;
    localparam logic [7:0] RST_COMP_LOW    = 8'h00;
    localparam logic [7:0] RST_MULT_COMP   = 8'h00;
    localparam logic [7:0] RST_SW_SET      = 8'h00;
    localparam logic [7:0] RST_SW_NEAR     = 8'h19;
    localparam logic [7:0] RST_SW_CONTACT  = 8'h19;

    // Writable bit masks; reserved bits read as zero
    localparam logic [7:0] MASK_CHAN_SET   = 8'h33;
    localparam logic [7:0] MASK_SW_SET     = 8'h77;

    localparam int DIV_LSB    = 4;
    localparam int MODE_LSB   = 0;
    localparam int BASE_LSB   = 6;
    localparam int GOAL_LSB   = 0;
    localparam int GOAL_W     = 6;
    localparam int GOAL_SHIFT = 5;
    localparam int COMP_HI_LSB = 6;
    localparam int COARSE_LSB = 4;
    localparam int FINE_LSB   = 0;
    localparam int LIN_BIT    = 6;
    localparam int THYS_LSB   = 4;
    localparam int SWAP_BIT   = 2;
    localparam int PHYS_LSB   = 0;
    localparam int TOUCH_SHIFT = 2;

    localparam logic [7:0] BASE_V0 = 8'h4b;
    localparam logic [7:0] BASE_V1 = 8'h64;
    localparam logic [7:0] BASE_V2 = 8'h96;
    localparam logic [7:0] BASE_V3 = 8'hc8;

    typedef enum logic [1:0] {
        TUNE_OFF     = 2'b00,
        TUNE_PARTIAL = 2'b01,
        TUNE_SEMI    = 2'b10,
        TUNE_FULL    = 2'b11
    } tune_mode_t;

    typedef enum logic [1:0] {
        HYS_NONE = 2'b00,
        HYS_QTR  = 2'b01,
        HYS_8TH  = 2'b10,
        HYS_16TH = 2'b11
    } hys_t;
endpackage

// *** logic/magnetic_channel_config_switch_ui.sv ***
// Register file and switch decision logic of the magnetic sensing channel pair
//
// Overview of operation
// - Charge divider field selects 1/2 to 1/16
// - Tuning mode: off, partial, semi-partial, or full tuning
// - Mode 10 fixes coarse multipliers only
// - Tuning base code selects 75/100/150/200
// - Tuning goal count is field times 32
// - Low compensation byte in full register
// - Compensation bits 9:8 from multiplier bits 7:6
// - Coarse multiplier 5:4, fine multiplier 3:0
// - Bit 6 enables output linearisation
// - Touch hysteresis off, 1/4, 1/8, 1/16
// - Proximity hysteresis off, 1/4, 1/8, 1/16
// - Bit 2 swaps field direction indication
// - Proximity threshold equals register value
// - Touch threshold is register value times four
`timescale 1ns/1ps
module magnetic_channel_config_switch_ui #(
    parameter int MEAS_W = 12
) (
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    input  wire logic              reg_wr_en,
    input  wire logic              reg_rd_en,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wr_data,
    output logic      [7:0]        reg_rd_data,
    output logic                   reg_rd_hit,
    input  wire logic              meas_valid,
    input  wire logic [MEAS_W-1:0] meas_value,
    input  wire logic              field_dir_raw,
    output logic      [1:0]        charge_rate_divider,
    output logic      [4:0]        charge_div_ratio,
    output logic                   tuning_enable,
    output logic                   tune_fine_free,
    output logic                   tune_coarse_free,
    output logic      [7:0]        tuning_base_value,
    output logic      [10:0]       tuning_goal_count,
    output logic      [9:0]        comp_value,
    output logic      [1:0]        mult_coarse,
    output logic      [3:0]        mult_fine,
    output logic                   linearise_en,
    output logic                   near_state,
    output logic                   contact_state,
    output logic                   field_dir_out
);
    // =====================================================================
    // Register file
    logic [7:0] chan_set_ff;
    logic [7:0] tune_set_ff;
    logic [7:0] comp_low_ff;
    logic [7:0] mult_comp_ff;
    logic [7:0] sw_set_ff;
    logic [7:0] sw_near_ff;
    logic [7:0] sw_contact_ff;

    wire wr_chan    = reg_wr_en && reg_addr == mag_cfg_pkg::ADDR_CHAN_SET;
    wire wr_tune    = reg_wr_en && reg_addr == mag_cfg_pkg::ADDR_TUNE_SET;
    wire wr_comp    = reg_wr_en && reg_addr == mag_cfg_pkg::ADDR_COMP_LOW;
    wire wr_mult    = reg_wr_en && reg_addr == mag_cfg_pkg::ADDR_MULT_COMP;
    wire wr_sw      = reg_wr_en && reg_addr == mag_cfg_pkg::ADDR_SW_SET;
    wire wr_near    = reg_wr_en && reg_addr == mag_cfg_pkg::ADDR_SW_NEAR;
    wire wr_contact = reg_wr_en && reg_addr == mag_cfg_pkg::ADDR_SW_CONTACT;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            chan_set_ff   <= mag_cfg_pkg::RST_CHAN_SET;
            tune_set_ff   <= mag_cfg_pkg::RST_TUNE_SET;
            comp_low_ff   <= mag_cfg_pkg::RST_COMP_LOW;
            mult_comp_ff  <= mag_cfg_pkg::RST_MULT_COMP;
            sw_set_ff     <= mag_cfg_pkg::RST_SW_SET;
            sw_near_ff    <= mag_cfg_pkg::RST_SW_NEAR;
            sw_contact_ff <= mag_cfg_pkg::RST_SW_CONTACT;
        end else begin
            if (wr_chan)    chan_set_ff   <= reg_wr_data & mag_cfg_pkg::MASK_CHAN_SET;
            if (wr_tune)    tune_set_ff   <= reg_wr_data;
            if (wr_comp)    comp_low_ff   <= reg_wr_data;
            if (wr_mult)    mult_comp_ff  <= reg_wr_data;
            if (wr_sw)      sw_set_ff     <= reg_wr_data & mag_cfg_pkg::MASK_SW_SET;
            if (wr_near)    sw_near_ff    <= reg_wr_data;
            if (wr_contact) sw_contact_ff <= reg_wr_data;
        end
    end

    // =====================================================================
    // Read port, registered
    logic [7:0] nxt_rd_data;
    logic       nxt_rd_hit;
    logic [7:0] rd_data_ff;
    logic       rd_hit_ff;

    always_comb begin
        nxt_rd_hit  = 1'b1;
        nxt_rd_data = 8'h00;
        unique case (reg_addr)
            mag_cfg_pkg::ADDR_CHAN_SET:   nxt_rd_data = chan_set_ff;
            mag_cfg_pkg::ADDR_TUNE_SET:   nxt_rd_data = tune_set_ff;
            mag_cfg_pkg::ADDR_COMP_LOW:   nxt_rd_data = comp_low_ff;
            mag_cfg_pkg::ADDR_MULT_COMP:  nxt_rd_data = mult_comp_ff;
            mag_cfg_pkg::ADDR_SW_SET:     nxt_rd_data = sw_set_ff;
            mag_cfg_pkg::ADDR_SW_NEAR:    nxt_rd_data = sw_near_ff;
            mag_cfg_pkg::ADDR_SW_CONTACT: nxt_rd_data = sw_contact_ff;
            default:                      nxt_rd_hit  = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_ff <= 8'h00;
            rd_hit_ff  <= 1'b0;
        end else begin
            rd_data_ff <= reg_rd_en ? nxt_rd_data : 8'h00;
            rd_hit_ff  <= reg_rd_en && nxt_rd_hit;
        end
    end
    assign reg_rd_data = rd_data_ff;
    assign reg_rd_hit  = rd_hit_ff;

    // =====================================================================
    // Field decode
    wire [1:0] div_code   = chan_set_ff[mag_cfg_pkg::DIV_LSB +: 2];
    wire [1:0] mode_code  = chan_set_ff[mag_cfg_pkg::MODE_LSB +: 2];
    wire [1:0] base_code  = tune_set_ff[mag_cfg_pkg::BASE_LSB +: 2];
    wire [5:0] goal_field = tune_set_ff[mag_cfg_pkg::GOAL_LSB +: mag_cfg_pkg::GOAL_W];
    wire [1:0] thys_code  = sw_set_ff[mag_cfg_pkg::THYS_LSB +: 2];
    wire [1:0] phys_code  = sw_set_ff[mag_cfg_pkg::PHYS_LSB +: 2];

    assign charge_rate_divider = div_code;
    // Ratio 2,4,8,16 as a one-hot count
    assign charge_div_ratio    = 5'h02 << div_code;

    assign tuning_enable    = mode_code != mag_cfg_pkg::TUNE_OFF;
    assign tune_fine_free   = mode_code == mag_cfg_pkg::TUNE_SEMI ||
                              mode_code == mag_cfg_pkg::TUNE_FULL;
    assign tune_coarse_free = mode_code == mag_cfg_pkg::TUNE_FULL;

    assign tuning_base_value = base_code == 2'b00 ? mag_cfg_pkg::BASE_V0 :
                               base_code == 2'b01 ? mag_cfg_pkg::BASE_V1 :
                               base_code == 2'b10 ? mag_cfg_pkg::BASE_V2 :
                                                    mag_cfg_pkg::BASE_V3;
    assign tuning_goal_count = 11'(goal_field) << mag_cfg_pkg::GOAL_SHIFT;

    assign comp_value  = {mult_comp_ff[mag_cfg_pkg::COMP_HI_LSB +: 2], comp_low_ff};
    assign mult_coarse = mult_comp_ff[mag_cfg_pkg::COARSE_LSB +: 2];
    assign mult_fine   = mult_comp_ff[mag_cfg_pkg::FINE_LSB +: 4];

    assign linearise_en  = sw_set_ff[mag_cfg_pkg::LIN_BIT];
    assign field_dir_out = field_dir_raw ^ sw_set_ff[mag_cfg_pkg::SWAP_BIT];

    // =====================================================================
    // Thresholds and hysteresis
    wire [9:0] near_thr    = {2'b00, sw_near_ff};
    wire [9:0] contact_thr = 10'(sw_contact_ff) << mag_cfg_pkg::TOUCH_SHIFT;

    function automatic logic [9:0] hys_amount(input logic [9:0] thr, input logic [1:0] code);
        logic [9:0] r;
        r = 10'h000;
        unique case (code)
            mag_cfg_pkg::HYS_NONE: r = 10'h000;
            mag_cfg_pkg::HYS_QTR:  r = thr >> 2;
            mag_cfg_pkg::HYS_8TH:  r = thr >> 3;
            mag_cfg_pkg::HYS_16TH: r = thr >> 4;
        endcase
        return r;
    endfunction

    wire [9:0] near_hys    = hys_amount(near_thr, phys_code);
    wire [9:0] contact_hys = hys_amount(contact_thr, thys_code);
    wire [9:0] near_rel    = near_thr - near_hys;
    wire [9:0] contact_rel = contact_thr - contact_hys;

    wire [MEAS_W+1:0] meas_ext = {2'b00, meas_value};
    wire near_on     = meas_ext >= {{(MEAS_W-8){1'b0}}, near_thr};
    wire near_off    = meas_ext <  {{(MEAS_W-8){1'b0}}, near_rel};
    wire contact_on  = meas_ext >= {{(MEAS_W-8){1'b0}}, contact_thr};
    wire contact_off = meas_ext <  {{(MEAS_W-8){1'b0}}, contact_rel};

    logic near_ff;
    logic contact_ff;
    wire  nxt_near    = near_ff ? !near_off : near_on;
    wire  nxt_contact = contact_ff ? !contact_off : contact_on;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            near_ff    <= 1'b0;
            contact_ff <= 1'b0;
        end else if (meas_valid) begin
            near_ff    <= nxt_near;
            contact_ff <= nxt_contact;
        end
    end
    assign near_state    = near_ff;
    assign contact_state = contact_ff;

    // =====================================================================
    // Assertions
    near_set_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        meas_valid && near_on |=> near_state)
        else $error("near state not set at threshold");
    near_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        near_state && meas_valid && !near_off |=> near_state)
        else $error("near state released inside hysteresis");
    contact_rel_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        contact_state && meas_valid && contact_off && !contact_on |=> !contact_state)
        else $error("contact state not released");
    contact_thr_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wr_contact |=> contact_thr == {$past(reg_wr_data), 2'b00})
        else $error("contact threshold not four times value");
    comp_join_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wr_mult ##1 !wr_mult && !wr_comp |=> comp_value[9:8] == $past(reg_wr_data[7:6], 2))
        else $error("compensation high bits wrong");
    goal_count_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wr_tune |=> tuning_goal_count == 11'($past(reg_wr_data[5:0]) * 32))
        else $error("goal count not times 32");
    base_val_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        base_code == 2'b10 |-> tuning_base_value == 8'h96)
        else $error("base value wrong");
    div_ratio_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wr_chan |=> charge_div_ratio == (5'h02 << $past(reg_wr_data[5:4])))
        else $error("charge divider wrong");
    semi_mode_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        mode_code == 2'b10 |-> tuning_enable && tune_fine_free && !tune_coarse_free)
        else $error("semi partial mode decode wrong");
    off_mode_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        mode_code == 2'b00 |-> !tuning_enable && !tune_fine_free)
        else $error("tuning not disabled");
    swap_dir_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wr_sw && reg_wr_data[2] |=> field_dir_out != field_dir_raw)
        else $error("direction not swapped");
    lin_mode_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wr_sw |=> linearise_en == $past(reg_wr_data[6]))
        else $error("linearise bit wrong");
    near_thr_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wr_near |=> near_thr == {2'b00, $past(reg_wr_data)})
        else $error("near threshold wrong");
    comp_low_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wr_comp |=> comp_value[7:0] == $past(reg_wr_data))
        else $error("compensation low byte wrong");
    mult_fields_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wr_mult |=> mult_coarse == $past(reg_wr_data[5:4]) && mult_fine == $past(reg_wr_data[3:0]))
        else $error("multiplier fields wrong");
    div_code_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wr_chan |=> charge_rate_divider == $past(reg_wr_data[5:4]))
        else $error("divider code wrong");
    partial_mode_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        mode_code == 2'b01 |-> tuning_enable && !tune_fine_free && !tune_coarse_free)
        else $error("partial mode decode wrong");
    full_mode_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        mode_code == 2'b11 |-> tuning_enable && tune_fine_free && tune_coarse_free)
        else $error("full mode decode wrong");
    base_low_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        base_code == 2'b00 |-> tuning_base_value == 8'h4b)
        else $error("base value 75 wrong");
    base_mid_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        base_code == 2'b01 |-> tuning_base_value == 8'h64)
        else $error("base value 100 wrong");
    base_top_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        base_code == 2'b11 |-> tuning_base_value == 8'hc8)
        else $error("base value 200 wrong");
    swap_off_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wr_sw && !reg_wr_data[2] |=> field_dir_out == field_dir_raw)
        else $error("direction swapped while disabled");
    near_rel_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        near_state && meas_valid && near_off |=> !near_state)
        else $error("near state not released");
    contact_set_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        meas_valid && contact_on |=> contact_state)
        else $error("contact state not set at threshold");
    contact_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        contact_state && meas_valid && !contact_off |=> contact_state)
        else $error("contact state released inside hysteresis");
    state_idle_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !meas_valid |=> $stable(near_state) && $stable(contact_state))
        else $error("state changed without a sample");
    // Read-back of the compensation and threshold registers
    rd_comp_hi_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        reg_rd_en && reg_addr == mag_cfg_pkg::ADDR_MULT_COMP |=> reg_rd_data[7:6] == $past(comp_value[9:8]))
        else $error("compensation high read-back wrong");
    rd_comp_lo_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        reg_rd_en && reg_addr == mag_cfg_pkg::ADDR_COMP_LOW |=> reg_rd_data == $past(comp_value[7:0]))
        else $error("compensation low read-back wrong");
    rd_near_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        reg_rd_en && reg_addr == mag_cfg_pkg::ADDR_SW_NEAR |=> reg_rd_data == $past(near_thr[7:0]))
        else $error("near threshold read-back wrong");
    rd_contact_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        reg_rd_en && reg_addr == mag_cfg_pkg::ADDR_SW_CONTACT |=> {reg_rd_data, 2'b00} == $past(contact_thr))
        else $error("contact threshold read-back wrong");

    near_cycle_c: cover property (@(posedge sys_clk) disable iff (!reset_n)
        !near_state ##1 near_state ##[1:50] !near_state);
    contact_set_c: cover property (@(posedge sys_clk) disable iff (!reset_n)
        !contact_state ##1 contact_state);
    hys_used_c: cover property (@(posedge sys_clk) disable iff (!reset_n)
        near_state && meas_valid && !near_on && !near_off);
    read_back_c: cover property (@(posedge sys_clk) disable iff (!reset_n)
        wr_sw ##1 reg_rd_en && reg_addr == mag_cfg_pkg::ADDR_SW_SET);
    refused_rd_c: cover property (@(posedge sys_clk) disable iff (!reset_n)
        reg_rd_en && !nxt_rd_hit ##1 !reg_rd_hit);
endmodule

// *** testbench/host_bus_model.sv ***
// Host model that reaches the block's registers through its parallel register port
`timescale 1ns/1ps
module host_bus_model (
    input  wire logic       sys_clk,
    output logic            reg_wr_en,
    output logic            reg_rd_en,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wr_data,
    input  wire logic [7:0] reg_rd_data,
    input  wire logic       reg_rd_hit
);
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
        reg_wr_data = 8'h00;
    end
    // Released lines show the inverse so a stale value never looks live
    task automatic release_bus();
        reg_addr = ~reg_addr;
        reg_wr_data = ~reg_wr_data;
    endtask
    task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge sys_clk);
        #1;
        reg_wr_en = 1'b1;
        reg_addr = addr;
        reg_wr_data = data;
        @(posedge sys_clk);
        #1;
        reg_wr_en = 1'b0;
        release_bus();
    endtask
    task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data, output logic hit);
        @(posedge sys_clk);
        #1;
        reg_rd_en = 1'b1;
        reg_addr = addr;
        @(posedge sys_clk);
        #1;
        data = reg_rd_data;
        hit = reg_rd_hit;
        reg_rd_en = 1'b0;
        release_bus();
    endtask
endmodule

// *** testbench/magnetic_channel_config_switch_ui_bench.sv ***
// Self-checking bench for the magnetic channel configuration and switch block
`timescale 1ns/1ps
module magnetic_channel_config_switch_ui_bench;
    logic sys_clk, reset_n, meas_valid, field_dir_raw;
    logic [11:0] meas_value;
    wire logic wr_en, rd_en, rd_hit, tune_en, fine_free, coarse_free, lin_en, near, contact, dir;
    wire logic [7:0] addr, wr_data, rd_data, base_val;
    wire logic [1:0] div_code, coarse;
    wire logic [4:0] div_ratio;
    wire logic [10:0] goal;
    wire logic [9:0] comp;
    wire logic [3:0] fine;
    int error_cnt = 0;
    int checks_done = 0;
    int pt, tt;
    logic [7:0] d;
    logic h;
    const logic [7:0] addrs[7] = '{8'h90, 8'h91, 8'h92, 8'h93, 8'ha0, 8'ha1, 8'ha2};
    const logic [7:0] rst_vals[7] = '{8'h03, 8'h50, 8'h00, 8'h00, 8'h00, 8'h19, 8'h19};
    const int bases[4] = '{75, 100, 150, 200};
    const int goals[4] = '{0, 63, 1, 42};
    host_bus_model host (.sys_clk(sys_clk), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
        .reg_addr(addr), .reg_wr_data(wr_data), .reg_rd_data(rd_data), .reg_rd_hit(rd_hit));
    magnetic_channel_config_switch_ui #(.MEAS_W(12)) DUT (.sys_clk(sys_clk), .reset_n(reset_n),
        .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr), .reg_wr_data(wr_data),
        .reg_rd_data(rd_data), .reg_rd_hit(rd_hit), .meas_valid(meas_valid),
        .meas_value(meas_value), .field_dir_raw(field_dir_raw), .charge_rate_divider(div_code),
        .charge_div_ratio(div_ratio), .tuning_enable(tune_en), .tune_fine_free(fine_free),
        .tune_coarse_free(coarse_free), .tuning_base_value(base_val),
        .tuning_goal_count(goal), .comp_value(comp), .mult_coarse(coarse), .mult_fine(fine),
        .linearise_en(lin_en), .near_state(near), .contact_state(contact),
        .field_dir_out(dir));
    // ==================================================
    // Clock, reset and checking helpers
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic tally_and_finish();
        if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic hit_exp);
        host.rd_reg(a, d, h);
        chk(16'(d), 16'(exp));
        chk(16'(h), 16'(hit_exp));
    endtask
    task automatic sample(input int v);
        @(posedge sys_clk);
        #1;
        meas_valid = 1'b1;
        meas_value = 12'(v);
        @(posedge sys_clk);
        #1;
        meas_valid = 1'b0;
        meas_value = ~meas_value;
    endtask
    initial begin
        #200000;
        error_cnt++;
        tally_and_finish();
    end
    // ==================================================
    // Test sequence
    initial begin
        reset_n = 1'b0;
        meas_valid = 1'b0;
        meas_value = 12'h000;
        field_dir_raw = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        reset_n = 1'b1;
        for (int i = 0; i < 7; i++) rd_chk(addrs[i], rst_vals[i], 1'b1);
        chk(16'(div_ratio), 16'h0002);
        chk(16'(base_val), 16'd100);
        chk(16'(goal), 16'd512);
        for (int i = 0; i < 4; i++) begin
            host.wr_reg(8'h90, {2'b11, 2'(i), 2'b11, 2'(i)});
            rd_chk(8'h90, {2'b00, 2'(i), 2'b00, 2'(i)}, 1'b1);
            chk(16'(div_ratio), 16'(2 << i));
            chk(16'(div_code), 16'(i));
            chk(16'(tune_en), 16'(i != 0));
            chk(16'(coarse_free), 16'(i == 3));
            chk(16'(fine_free), 16'(i >= 2));
            host.wr_reg(8'h91, {2'(i), 6'(goals[i])});
            rd_chk(8'h91, {2'(i), 6'(goals[i])}, 1'b1);
            chk(16'(base_val), 16'(bases[i]));
            chk(16'(goal), 16'(goals[i] * 32));
        end
        host.wr_reg(8'h92, 8'ha5);
        host.wr_reg(8'h93, 8'hdb);
        host.wr_reg(8'h94, 8'h11);
        rd_chk(8'h94, 8'h00, 1'b0);
        rd_chk(8'h93, 8'hdb, 1'b1);
        chk(16'(comp), 16'h03a5);
        chk(16'(coarse), 16'h0001);
        chk(16'(fine), 16'h000b);
        for (int s = 1; s >= 0; s--) begin
            host.wr_reg(8'ha0, s ? 8'hff : 8'h00);
            rd_chk(8'ha0, s ? 8'h77 : 8'h00, 1'b1);
            chk(16'(lin_en), 16'(s));
            for (int j = 0; j < 2; j++) begin
                field_dir_raw = 1'(j);
                #1;
                chk(16'(dir), 16'(j ^ s));
            end
        end
        // Thresholds are set before any measurement arrives
        host.wr_reg(8'ha1, 8'h40);
        host.wr_reg(8'ha2, 8'h20);
        for (int k = 0; k < 4; k++) begin
            host.wr_reg(8'ha0, {2'b00, 2'(k), 2'b00, 2'(k)});
            pt = (k == 0) ? 0 : 64 >> (k + 1);
            tt = (k == 0) ? 0 : 128 >> (k + 1);
            sample(127);
            chk(16'(contact), 16'h0000);
            chk(16'(near), 16'h0001);
            sample(128);
            chk(16'(contact), 16'h0001);
            @(posedge sys_clk);
            #1;
            chk(16'(contact), 16'h0001);
            sample(128 - tt);
            chk(16'(contact), 16'h0001);
            sample(127 - tt);
            chk(16'(contact), 16'h0000);
            sample(64 - pt);
            chk(16'(near), 16'h0001);
            sample(63 - pt);
            chk(16'(near), 16'h0000);
            sample(63);
            chk(16'(near), 16'h0000);
        end
        tally_and_finish();
    end
endmodule
